// file: design/drd_pkg.sv
// package of constants and types for the display reset defaults block
// Operation
// - while the hardware reset pin is low the display is held off in the full 128 by 64 configuration.
// - reset restores normal column and row mapping, first column driver at column 0 and first row driver at row 0.
// - reset clears the serial shift register and drops any partly received byte.
// - reset sets the display start line to memory row 0.
// - reset loads the column address counter with 0.
// - reset selects the normal, not reversed, scan direction of the row drivers.
// - reset loads the contrast register with 7Fh.
// - reset selects normal display mode where pixels follow memory, as command A4h does.
package drd_pkg;

    // =========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] DRD_OFS_CTRL     = 8'h00;
    localparam logic [7:0] DRD_OFS_MUX      = 8'h04;
    localparam logic [7:0] DRD_OFS_START    = 8'h08;
    localparam logic [7:0] DRD_OFS_COLUMN   = 8'h0C;
    localparam logic [7:0] DRD_OFS_CONTRAST = 8'h10;
    localparam logic [7:0] DRD_OFS_STATUS   = 8'h14;

    // =========================================================
    // field positions
    localparam int DRD_CTRL_ON_BIT     = 0;
    localparam int DRD_CTRL_SEG_BIT    = 1;
    localparam int DRD_CTRL_COM_BIT    = 2;
    localparam int DRD_CTRL_ENTIRE_BIT = 3;
    localparam int DRD_STAT_CNT_LSB    = 8;
    localparam int DRD_STAT_RST_BIT    = 16;

    // =========================================================
    // reset values
    localparam logic [5:0] DRD_RST_MUX      = 6'h3F;  // 64 rows
    localparam logic [5:0] DRD_RST_START    = 6'h00;
    localparam logic [6:0] DRD_RST_COLUMN   = 7'h00;
    localparam logic [7:0] DRD_RST_CONTRAST = 8'h7F;

    // =========================================================
    // carriers
    typedef struct packed {
        logic       display_on;
        logic       seg_remap;
        logic       com_reverse;
        logic       entire_on;
        logic [5:0] mux_ratio;
        logic [5:0] start_line;
        logic [6:0] column;
        logic [7:0] contrast;
    } drd_cfg_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } drd_apb_req_type;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } drd_apb_rsp_type;

    typedef struct packed {
        logic sclk;
        logic sdin;
        logic cs_n;
        logic dc;
    } drd_ser_pin_type;

    localparam drd_cfg_type DRD_CFG_RESET = '{display_on: 1'b0, seg_remap: 1'b0, com_reverse: 1'b0,
        entire_on: 1'b0, mux_ratio: DRD_RST_MUX, start_line: DRD_RST_START, column: DRD_RST_COLUMN,
        contrast: DRD_RST_CONTRAST};
    localparam drd_ser_pin_type DRD_PIN_IDLE = '{sclk: 1'b0, sdin: 1'b0, cs_n: 1'b1, dc: 1'b0};

endpackage : drd_pkg

// file: design/drd_display_reset.sv
// display configuration state with hardware reset defaults, serial byte intake and apb access
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module drd_display_reset
    import drd_pkg::*;
(
    input  wire logic            CORE_CLK_IN,
    input  wire logic            RSTN_IN,
    input  wire logic            HW_RESET_N_IN,
    input  wire drd_apb_req_type APB_REQ_IN,
    output drd_apb_rsp_type      APB_RSP_OUT,
    input  wire drd_ser_pin_type SER_PINS_IN,
    output drd_cfg_type          CFG_OUT,
    output logic                 RESET_ACTIVE_OUT
);

    // =========================================================
    // state
    typedef struct packed {
        drd_apb_rsp_type rsp;
        logic            rst_s1;
        logic            rst_s2;
        logic            rst_active;
        drd_ser_pin_type pin_s1;
        drd_ser_pin_type pin_s2;
        logic            sclk_d;
        drd_cfg_type     cfg;
        logic [7:0]      shift;
        logic [2:0]      bit_cnt;
        logic [7:0]      rx_byte;
    } drd_state_type;

    localparam drd_state_type DRD_STATE_RESET = '{rsp: '0, rst_s1: 1'b0, rst_s2: 1'b0, rst_active: 1'b1,
        pin_s1: DRD_PIN_IDLE, pin_s2: DRD_PIN_IDLE, sclk_d: 1'b0, cfg: DRD_CFG_RESET, shift: 8'h00,
        bit_cnt: 3'h0, rx_byte: 8'h00};

    drd_state_type s;
    drd_state_type next_s;
    logic          apb_setup;
    logic          apb_fire;
    logic          sclk_rise;
    logic          hw_rst;

    // =========================================================
    // decode helpers
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == DRD_OFS_CTRL) || (a == DRD_OFS_MUX) || (a == DRD_OFS_START) ||
                  (a == DRD_OFS_COLUMN) || (a == DRD_OFS_CONTRAST) || (a == DRD_OFS_STATUS);
    endfunction : addr_ok

    function automatic logic [31:0] read_word(input logic [7:0] a, input drd_state_type st);
        read_word = 32'h0000_0000;
        case (a)
            DRD_OFS_CTRL: begin
                read_word[DRD_CTRL_ON_BIT]     = st.cfg.display_on;
                read_word[DRD_CTRL_SEG_BIT]    = st.cfg.seg_remap;
                read_word[DRD_CTRL_COM_BIT]    = st.cfg.com_reverse;
                read_word[DRD_CTRL_ENTIRE_BIT] = st.cfg.entire_on;
            end
            DRD_OFS_MUX:      read_word[5:0] = st.cfg.mux_ratio;
            DRD_OFS_START:    read_word[5:0] = st.cfg.start_line;
            DRD_OFS_COLUMN:   read_word[6:0] = st.cfg.column;
            DRD_OFS_CONTRAST: read_word[7:0] = st.cfg.contrast;
            DRD_OFS_STATUS: begin
                read_word[7:0]                                = st.rx_byte;
                read_word[DRD_STAT_CNT_LSB +: 3]              = st.bit_cnt;
                read_word[DRD_STAT_RST_BIT]                   = st.rst_active;
            end
            default: read_word = 32'h0000_0000;
        endcase
    endfunction : read_word

    // =========================================================
    // event terms
    assign apb_setup = APB_REQ_IN.psel && !APB_REQ_IN.penable;
    assign apb_fire  = APB_REQ_IN.psel && APB_REQ_IN.penable && s.rsp.pready;
    assign sclk_rise = !s.pin_s2.cs_n && s.pin_s2.sclk && !s.sclk_d;
    assign hw_rst    = !s.rst_s2;

    // =========================================================
    // next state
    always_comb begin
        next_s = s;
        // pin synchronisers; only the second stage is read by logic
        next_s.rst_s1     = HW_RESET_N_IN;
        next_s.rst_s2     = s.rst_s1;
        next_s.rst_active = hw_rst;
        next_s.pin_s1     = SER_PINS_IN;
        next_s.pin_s2     = s.pin_s1;
        next_s.sclk_d     = s.pin_s2.sclk;

        // apb answer is built in the setup cycle, ready one cycle later
        next_s.rsp.pready = apb_setup;
        if (apb_setup) begin
            next_s.rsp.pslverr = !addr_ok(APB_REQ_IN.paddr) || (APB_REQ_IN.pwrite && hw_rst);
            next_s.rsp.prdata  = APB_REQ_IN.pwrite ? 32'h0000_0000 : read_word(APB_REQ_IN.paddr, s);
        end

        // serial byte assembly, msb first
        if (sclk_rise) begin
            next_s.shift   = {s.shift[6:0], s.pin_s2.sdin};
            next_s.bit_cnt = s.bit_cnt + 3'h1;
            if (s.bit_cnt == 3'h7) begin
                next_s.rx_byte = {s.shift[6:0], s.pin_s2.sdin};
                // a data byte advances the column counter, wrapping at 128
                if (s.pin_s2.dc) begin
                    next_s.cfg.column = s.cfg.column + 7'h01;
                end
            end
        end
        // deselect abandons a partial byte so the next one starts aligned
        if (s.pin_s2.cs_n) begin
            next_s.bit_cnt = 3'h0;
        end

        // register writes take effect on the access edge only
        if (apb_fire && APB_REQ_IN.pwrite && !s.rsp.pslverr) begin
            case (APB_REQ_IN.paddr)
                DRD_OFS_CTRL: begin
                    next_s.cfg.display_on  = APB_REQ_IN.pwdata[DRD_CTRL_ON_BIT];
                    next_s.cfg.seg_remap   = APB_REQ_IN.pwdata[DRD_CTRL_SEG_BIT];
                    next_s.cfg.com_reverse = APB_REQ_IN.pwdata[DRD_CTRL_COM_BIT];
                    next_s.cfg.entire_on   = APB_REQ_IN.pwdata[DRD_CTRL_ENTIRE_BIT];
                end
                DRD_OFS_MUX:      next_s.cfg.mux_ratio  = APB_REQ_IN.pwdata[5:0];
                DRD_OFS_START:    next_s.cfg.start_line = APB_REQ_IN.pwdata[5:0];
                DRD_OFS_COLUMN:   next_s.cfg.column     = APB_REQ_IN.pwdata[6:0];
                DRD_OFS_CONTRAST: next_s.cfg.contrast   = APB_REQ_IN.pwdata[7:0];
                default: begin
                end
            endcase
        end

        // hardware reset overrides the configuration, shift register and bit count for as long as the pin is low
        if (hw_rst) begin
            next_s.cfg     = DRD_CFG_RESET;
            next_s.shift   = 8'h00;
            next_s.bit_cnt = 3'h0;
        end
    end

    // =========================================================
    // state register
    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            s <= DRD_STATE_RESET;
        end else begin
            s <= next_s;
        end
    end

    // outputs taken straight from the state flops
    assign APB_RSP_OUT      = s.rsp;
    assign CFG_OUT          = s.cfg;
    assign RESET_ACTIVE_OUT = s.rst_active;

    // =========================================================
    // checks
    // one clock domain, so one default clock and one default disable serve all checks
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RSTN_IN);

    // forcing lands one edge after the synchronised pin is seen low
    AST_RESET_DISPLAY_OFF: assert property (
        hw_rst |=> !CFG_OUT.display_on && CFG_OUT.mux_ratio == DRD_RST_MUX)
        else $error("display not off or not full size under reset");

    // the first reset edge still shows the old mapping, so look from the second on
    AST_RESET_SEG_MAP: assert property (
        hw_rst ##1 hw_rst |=> !CFG_OUT.seg_remap && !$past(CFG_OUT.seg_remap))
        else $error("column mapping not normal under reset");

    // shift register and bit count emptied
    AST_RESET_SHIFT_CLEAR: assert property (
        hw_rst |=> s.shift == 8'h00 && s.bit_cnt == 3'h0)
        else $error("serial shift register not cleared under reset");

    // with the count cleared no byte can complete while reset holds
    AST_RESET_BYTE_DROPPED: assert property (
        hw_rst ##1 hw_rst |=> $stable(s.rx_byte))
        else $error("serial byte taken under reset");

    // deselect drops a partial byte
    AST_DESELECT_CLEAR: assert property (
        s.pin_s2.cs_n |=> s.bit_cnt == 3'h0)
        else $error("partial byte kept across deselect");

    // start line back at memory row zero
    AST_RESET_START_LINE: assert property (
        $fell(s.rst_s2) |=> CFG_OUT.start_line == DRD_RST_START)
        else $error("start line not zero after reset");

    // column counter cleared
    AST_RESET_COLUMN: assert property (
        hw_rst |=> CFG_OUT.column == DRD_RST_COLUMN)
        else $error("column counter not zero under reset");

    // row scan in its normal direction
    AST_RESET_COM_DIR: assert property (
        hw_rst |=> !CFG_OUT.com_reverse)
        else $error("row scan reversed under reset");

    // contrast back at mid value
    AST_RESET_CONTRAST: assert property (
        hw_rst |=> CFG_OUT.contrast == DRD_RST_CONTRAST)
        else $error("contrast not at default under reset");

    // pixels follow memory again
    AST_RESET_NORMAL_MODE: assert property (
        hw_rst |=> !CFG_OUT.entire_on)
        else $error("display mode not normal under reset");

    // the whole configuration stays at its defaults for as long as reset holds
    AST_RESET_HELD: assert property (
        hw_rst ##1 hw_rst |-> CFG_OUT == DRD_CFG_RESET)
        else $error("configuration left defaults under reset");

    // reset flag follows the synchronised pin one edge later
    AST_RESET_FLAG_SET: assert property (
        hw_rst |=> RESET_ACTIVE_OUT)
        else $error("reset flag low under reset");

    // and drops once the pin is released
    AST_RESET_FLAG_CLEAR: assert property (
        !hw_rst |=> !RESET_ACTIVE_OUT)
        else $error("reset flag high outside reset");

    // writes are refused while the synchronised reset is active
    AST_WRITE_REFUSED: assert property (
        apb_setup && APB_REQ_IN.pwrite && hw_rst |=> APB_RSP_OUT.pready && APB_RSP_OUT.pslverr)
        else $error("write during reset not refused");

    // reads of mapped registers stay open, reset or not
    AST_READ_ALLOWED: assert property (
        apb_setup && !APB_REQ_IN.pwrite && addr_ok(APB_REQ_IN.paddr) |=> APB_RSP_OUT.pready && !APB_RSP_OUT.pslverr)
        else $error("read of a mapped register refused");

    // outside reset an accepted write lands at the access edge
    AST_WRITE_CONTRAST: assert property (
        apb_fire && APB_REQ_IN.pwrite && !s.rsp.pslverr && !hw_rst &&
        APB_REQ_IN.paddr == DRD_OFS_CONTRAST |=> CFG_OUT.contrast == $past(APB_REQ_IN.pwdata[7:0]))
        else $error("contrast write lost");

endmodule : drd_display_reset

// file: testbench/drd_host_model.sv
// host model driving the serial pins and the display reset pin
`timescale 1ns/1ps
module drd_host_model
    import drd_pkg::*;
(
    input  wire logic      clk_in,
    output drd_ser_pin_type pins_out,
    output logic           hw_reset_n_out
);
    // =========================================================
    // idle pins: deselected, clock low
    initial begin
        pins_out       = DRD_PIN_IDLE;
        hw_reset_n_out = 1'b1;
    end
    // =========================================================
    // msb first, three core cycles low and four high per clock for safe sampling
    task automatic send_bits(input logic [7:0] b, input logic dc, input int n, input logic release_cs);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            pins_out <= '{sclk: 1'b0, sdin: b[7-i], cs_n: 1'b0, dc: dc};
            repeat (3) @(posedge clk_in);
            pins_out.sclk <= 1'b1;
            repeat (3) @(posedge clk_in);
        end
        @(posedge clk_in);
        // released data line flips so a stale bit is never mistaken for data
        if (release_cs) begin
            pins_out <= '{sclk: 1'b0, sdin: ~pins_out.sdin, cs_n: 1'b1, dc: ~dc};
        end else begin
            pins_out.sclk <= 1'b0;
        end
    endtask : send_bits
    // recovery reset after a disturbed image
    task automatic set_reset(input logic level);
        @(posedge clk_in);
        hw_reset_n_out <= level;
    endtask : set_reset
endmodule : drd_host_model

// file: testbench/tb_top.sv
// self-checking bench for the display reset defaults block
`timescale 1ns/1ps
module tb_top
    import drd_pkg::*;
;
    logic            clk;
    logic            rstn;
    logic            hwn;
    drd_apb_req_type req;
    drd_apb_rsp_type rsp;
    drd_ser_pin_type pins;
    drd_cfg_type     cfg;
    logic            ract;
    logic [31:0]     rd;
    logic            err;
    int              mismatches;
    int              num_checks;

    drd_display_reset u_drd_display_reset (.CORE_CLK_IN(clk), .RSTN_IN(rstn), .HW_RESET_N_IN(hwn),
        .APB_REQ_IN(req), .APB_RSP_OUT(rsp), .SER_PINS_IN(pins), .CFG_OUT(cfg), .RESET_ACTIVE_OUT(ract));
    drd_host_model u_drd_host_model (.clk_in(clk), .pins_out(pins), .hw_reset_n_out(hwn));

    // =========================================================
    // clock, 100 MHz
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("mismatches %0d num_checks %0d", mismatches, num_checks);
        if (mismatches == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : complete_run

    // =========================================================
    // apb master: hold the request until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        // no cycle count assumed; only the watchdog ends a hung transfer
        do begin
            @(posedge clk);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask : apb

    task automatic t_defaults;
        check(32'(cfg), 32'(DRD_CFG_RESET));
        apb(1'b0, DRD_OFS_CONTRAST, '0);
        check(rd, 32'(DRD_RST_CONTRAST));
    endtask : t_defaults

    // non-default state, partial byte, then hardware reset
    task automatic t_hw_reset;
        apb(1'b1, DRD_OFS_CTRL, 32'h0000000F);
        apb(1'b1, DRD_OFS_MUX, 32'h0000001F);
        apb(1'b1, DRD_OFS_START, 32'h00000005);
        apb(1'b1, DRD_OFS_COLUMN, 32'h00000009);
        apb(1'b1, DRD_OFS_CONTRAST, 32'h00000020);
        check(32'(err), 32'h0);
        // the write lands at the access edge, so look one edge later
        @(posedge clk);
        check(32'(cfg.contrast), 32'h20);
        check(32'(cfg), 32'({4'hF, 6'h1F, 6'h05, 7'h09, 8'h20}));
        u_drd_host_model.send_bits(8'hA5, 1'b1, 3, 1'b0);
        u_drd_host_model.set_reset(1'b0);
        repeat (4) @(posedge clk);
        check(32'({cfg.display_on, cfg.mux_ratio}), 32'({1'b0, DRD_RST_MUX}));
        check(32'({cfg.seg_remap, cfg.com_reverse}), 32'h0);
        check(32'(cfg.start_line), 32'(DRD_RST_START));
        check(32'(cfg.column), 32'(DRD_RST_COLUMN));
        check(32'(cfg.com_reverse), 32'h0);
        check(32'(cfg.contrast), 32'(DRD_RST_CONTRAST));
        check(32'(cfg.entire_on), 32'h0);
        check(32'(ract), 32'h1);
        // reads stay open under reset and show the partial byte dropped
        apb(1'b0, DRD_OFS_STATUS, '0);
        check(32'(rd[DRD_STAT_RST_BIT]), 32'h1);
        check(32'(rd[DRD_STAT_CNT_LSB +: 3]), 32'h0);
        apb(1'b1, DRD_OFS_CONTRAST, 32'h00000011);
        check(32'(err), 32'h1);
        @(posedge clk);
        check(32'(cfg.contrast), 32'(DRD_RST_CONTRAST));
        u_drd_host_model.set_reset(1'b1);
        repeat (6) @(posedge clk);
        check(32'(ract), 32'h0);
        // five more bits must not complete the dropped byte
        u_drd_host_model.send_bits(8'hFF, 1'b1, 5, 1'b0);
        repeat (6) @(posedge clk);
        apb(1'b0, DRD_OFS_STATUS, '0);
        check(32'(rd[DRD_STAT_CNT_LSB +: 3]), 32'h5);
        check(32'(cfg.column), 32'h0);
        u_drd_host_model.send_bits(8'h00, 1'b1, 0, 1'b1);
    endtask : t_hw_reset

    // full data byte, then an unmapped read
    task automatic t_serial;
        u_drd_host_model.send_bits(8'h3C, 1'b1, 8, 1'b1);
        repeat (8) @(posedge clk);
        apb(1'b0, DRD_OFS_STATUS, '0);
        check(32'(rd[7:0]), 32'h3C);
        check(32'(cfg.column), 32'h1);
        apb(1'b0, 8'h40, '0);
        check(32'(err), 32'h1);
        check(rd, 32'h0);
    endtask : t_serial

    // =========================================================
    // main sequence
    initial begin
        mismatches = 0;
        num_checks = 0;
        rstn = 1'b0;
        req = '0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        t_defaults();
        t_hw_reset();
        t_serial();
        complete_run();
    end

    // watchdog, far beyond the few hundred cycles needed
    initial begin
        #200us;
        mismatches++;
        complete_run();
    end
endmodule : tb_top
